/* File: sensor_irq_wait_cfg.v */
// Two-wire register slave, wait timer and interrupt qualification of the light/proximity sensor
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_defs.vh"

// Overview of operation
// - Wait steps are 2.73 ms each, twelve times longer when long wait is set.
// - Wait count is two's complement: 0xFF gives one step, 0x00 gives 256.
// - Channel 0 light result below low or above high threshold is out of range.
// - Light thresholds built from low/high byte pairs, low threshold first.
// - Proximity result below low or above high threshold is out of range.
// - Proximity thresholds built from low/high byte pairs, low threshold first.
// - Light uses only channel 0; light and proximity filters are independent.
// - Proximity filter code 0 fires on every result, N needs N consecutive out-of-range.
// - Light filter codes 1-3 need 1-3, codes 4-15 need 5-60 in fives.
// - Reduced drive bit lowers the LED current by a factor of nine.
// - LED pin emits the programmed pulse count during proximity accumulate.
// - LED pulses run at 62.5 kHz.
// - Interrupts raise only while their mask bit is set.
// - Special-function command 5, 6, 7 clears proximity, light, or both.
// - Wait timer runs only if wait is enabled at its start, otherwise skipped.
module sensor_irq_wait_cfg #(
	parameter [6:0]   I2C_ADDR      = 7'h2A, // Arbitrary bus address
	parameter integer WAIT_STEP_CYC = `WAIT_STEP_NS / `CLK_PERIOD_NS,
	parameter integer STEP_W        = 15
)(
	input  wire        clk,
	input  wire        reset,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	input  wire        prox_irq_mask,
	input  wire        light_irq_mask,
	input  wire        wait_enable,
	input  wire        wait_start,
	input  wire [15:0] light_channel_zero,
	input  wire        light_result_valid,
	input  wire [15:0] prox_result,
	input  wire        prox_result_valid,
	input  wire        prox_accum_start,
	output reg         irq_n,
	output wire        prox_irq_pending,
	output wire        light_irq_pending,
	output wire        reduced_led_drive,
	output wire        led_drive_output,
	output wire        led_pulses_done,
	output reg         wait_busy,
	output reg         wait_done
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_AACK = 3'h2;
	localparam [2:0] S_WR   = 3'h3;
	localparam [2:0] S_WACK = 3'h4;
	localparam [2:0] S_RD   = 3'h5;
	localparam [2:0] S_RACK = 3'h6;

	localparam [STEP_W-1:0] STEP_LAST  = WAIT_STEP_CYC[STEP_W-1:0] - 1'b1;
	localparam integer      LED_PERIOD = `LED_PULSE_PERIOD_NS / `CLK_PERIOD_NS;

	// Register storage, index 0 is the wait duration
	reg  [7:0]        regs_q [0:11];
	reg  [2:0]        state_q;
	reg  [3:0]        bit_cnt_q;
	reg  [7:0]        shift_q;
	reg               rw_q;
	reg               cmd_next_q;
	reg  [4:0]        ptr_q;
	reg               auto_q;
	reg               mack_q;
	reg               clr_prox_q;
	reg               clr_light_q;
	reg               scl_q;
	reg               sda_q;
	reg  [STEP_W-1:0] tick_q;
	reg  [3:0]        mult_q;
	reg  [8:0]        steps_q;
	reg               long_q;
	reg  [7:0]        rd_byte;
	wire              scl_rise;
	wire              scl_fall;
	wire              start_cond;
	wire              stop_cond;
	wire              byte_end;
	wire              wr_strobe;
	wire [1:0]        cmd_type;
	wire [4:0]        cmd_add;
	wire [7:0]        wait_duration_count;
	wire [7:0]        options;
	wire [7:0]        filter_counts;
	wire [7:0]        led_pulse_total;
	wire [3:0]        prox_filter_count;
	wire [3:0]        light_filter_count;
	wire              long_wait_select;
	wire [15:0]       light_low;
	wire [15:0]       light_high;
	wire [15:0]       prox_low;
	wire [15:0]       prox_high;
	integer           i;

	function in_map;
		input [4:0] a;
		begin
			in_map = (a >= `REG_FIRST) && (a <= `REG_LAST);
		end
	endfunction

	function [3:0] reg_index;
		input [4:0] a;
		reg   [4:0] d;
		begin
			d = a - `REG_FIRST;
			reg_index = d[3:0];
		end
	endfunction

	// Open drain: the pin is only ever pulled low
	assign sda_out = 1'b0;

	assign scl_rise   = scl_in && !scl_q;
	assign scl_fall   = !scl_in && scl_q;
	assign start_cond = scl_in && scl_q && sda_q && !sda_in;
	assign stop_cond  = scl_in && scl_q && !sda_q && sda_in;
	assign byte_end   = (bit_cnt_q == 4'h8);
	assign wr_strobe  = scl_fall && (state_q == S_WR) && byte_end && !cmd_next_q;
	assign cmd_type   = shift_q[6:5];
	assign cmd_add    = shift_q[4:0];

	assign wait_duration_count = regs_q[reg_index(`REG_WAIT_DURATION)];
	assign options             = regs_q[reg_index(`REG_WAIT_DRIVE_OPTIONS)];
	assign filter_counts       = regs_q[reg_index(`REG_FILTER_COUNTS)];
	assign led_pulse_total     = regs_q[reg_index(`REG_LED_PULSE_COUNT)];
	assign prox_filter_count   = filter_counts[`PROX_FILTER_MSB:`PROX_FILTER_LSB];
	assign light_filter_count  = filter_counts[`LIGHT_FILTER_MSB:`LIGHT_FILTER_LSB];
	assign long_wait_select    = options[`CFG_LONG_WAIT_BIT];
	assign reduced_led_drive   = options[`CFG_REDUCED_DRIVE_BIT];

	// Lower byte at the lower address, low threshold before high
	assign light_low  = {regs_q[reg_index(`REG_LIGHT_LOW_HI)],
		regs_q[reg_index(`REG_LIGHT_LOW_LO)]};
	assign light_high = {regs_q[reg_index(`REG_LIGHT_HIGH_HI)],
		regs_q[reg_index(`REG_LIGHT_HIGH_LO)]};
	assign prox_low   = {regs_q[reg_index(`REG_PROX_LOW_HI)],
		regs_q[reg_index(`REG_PROX_LOW_LO)]};
	assign prox_high  = {regs_q[reg_index(`REG_PROX_HIGH_HI)],
		regs_q[reg_index(`REG_PROX_HIGH_LO)]};

	// Addresses outside this block read as zero
	always @* begin
		rd_byte = 8'h00;
		if (in_map(ptr_q))
			rd_byte = regs_q[reg_index(ptr_q)];
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Bus protocol: address, command byte, then data bytes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q     <= S_IDLE;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			sda_oe      <= 1'b0;
			rw_q        <= 1'b0;
			cmd_next_q  <= 1'b0;
			ptr_q       <= 5'h00;
			auto_q      <= 1'b0;
			mack_q      <= 1'b0;
			clr_prox_q  <= 1'b0;
			clr_light_q <= 1'b0;
		end else begin
			clr_prox_q  <= 1'b0;
			clr_light_q <= 1'b0;
			if (start_cond) begin
				state_q   <= S_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe    <= 1'b0;
			end else if (stop_cond) begin
				state_q <= S_IDLE;
				sda_oe  <= 1'b0;
			end else if (scl_rise) begin
				if (state_q == S_ADDR || state_q == S_WR) begin
					shift_q   <= {shift_q[6:0], sda_in};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (state_q == S_RD) begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (state_q == S_RACK) begin
					mack_q <= !sda_in;
				end
			end else if (scl_fall) begin
				case (state_q)
				S_IDLE: begin
					sda_oe <= 1'b0;
				end
				S_ADDR: begin
					if (byte_end) begin
						if (shift_q[7:1] == I2C_ADDR) begin
							sda_oe  <= 1'b1;
							rw_q    <= shift_q[0];
							state_q <= S_AACK;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					bit_cnt_q  <= 4'h0;
					cmd_next_q <= !rw_q;
					if (rw_q) begin
						shift_q <= rd_byte;
						sda_oe  <= !rd_byte[7];
						state_q <= S_RD;
					end else begin
						sda_oe  <= 1'b0;
						state_q <= S_WR;
					end
				end
				S_WR: begin
					if (byte_end) begin
						sda_oe     <= 1'b1;
						state_q    <= S_WACK;
						cmd_next_q <= 1'b0;
						if (cmd_next_q) begin
							if (shift_q[`CMD_SELECT_BIT]) begin
								if (cmd_type == `CMD_TYPE_SPECIAL) begin
									clr_prox_q  <= (cmd_add == `SF_CLEAR_PROX) ||
										(cmd_add == `SF_CLEAR_BOTH);
									clr_light_q <= (cmd_add == `SF_CLEAR_LIGHT) ||
										(cmd_add == `SF_CLEAR_BOTH);
								end else begin
									ptr_q  <= cmd_add;
									auto_q <= (cmd_type == `CMD_TYPE_AUTO_INC);
								end
							end
						end else if (auto_q) begin
							ptr_q <= ptr_q + 5'h01;
						end
					end
				end
				S_WACK: begin
					sda_oe    <= 1'b0;
					bit_cnt_q <= 4'h0;
					state_q   <= S_WR;
				end
				S_RD: begin
					if (byte_end) begin
						sda_oe  <= 1'b0;
						state_q <= S_RACK;
						if (auto_q)
							ptr_q <= ptr_q + 5'h01;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						sda_oe  <= !shift_q[6];
					end
				end
				S_RACK: begin
					bit_cnt_q <= 4'h0;
					if (mack_q) begin
						shift_q <= rd_byte;
						sda_oe  <= !rd_byte[7];
						state_q <= S_RD;
					end else begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
					sda_oe  <= 1'b0;
				end
				endcase
			end
		end
	end

	// Register file writes; unmapped addresses are ignored
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			for (i = 0; i < 12; i = i + 1)
				regs_q[i] <= `RST_OTHER;
			regs_q[0] <= `RST_WAIT_DURATION;
		end else if (wr_strobe && in_map(ptr_q)) begin
			regs_q[reg_index(ptr_q)] <= shift_q;
		end
	end

	// Wait timer; count and long option are latched at start so a
	// rewrite mid-wait cannot stretch the current wait
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_busy <= 1'b0;
			wait_done <= 1'b0;
			tick_q    <= {STEP_W{1'b0}};
			mult_q    <= 4'h0;
			steps_q   <= 9'h000;
			long_q    <= 1'b0;
		end else begin
			wait_done <= 1'b0;
			if (!wait_busy) begin
				if (wait_start) begin
					if (!wait_enable) begin
						wait_done <= 1'b1;
					end else begin
						wait_busy <= 1'b1;
						tick_q    <= {STEP_W{1'b0}};
						mult_q    <= 4'h0;
						steps_q   <= `WAIT_STEPS_FULL - {1'b0, wait_duration_count};
						long_q    <= long_wait_select;
					end
				end
			end else if (tick_q == STEP_LAST) begin
				tick_q <= {STEP_W{1'b0}};
				if (long_q && mult_q != `LONG_WAIT_MULT - 4'h1) begin
					mult_q <= mult_q + 4'h1;
				end else begin
					mult_q  <= 4'h0;
					steps_q <= steps_q - 9'h001;
					if (steps_q == 9'h001) begin
						wait_busy <= 1'b0;
						wait_done <= 1'b1;
					end
				end
			end else begin
				tick_q <= tick_q + {{(STEP_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Separate filters; light looks at channel 0 only
	persist_filter #(
		.SCALED(1)
	) u_light_filter (
		.clk          (clk),
		.reset        (reset),
		.result_valid (light_result_valid),
		.result       (light_channel_zero),
		.low_thresh   (light_low),
		.high_thresh  (light_high),
		.filter_code  (light_filter_count),
		.irq_mask     (light_irq_mask),
		.irq_clear    (clr_light_q),
		.irq_pending_q(light_irq_pending)
	);

	persist_filter #(
		.SCALED(0)
	) u_prox_filter (
		.clk          (clk),
		.reset        (reset),
		.result_valid (prox_result_valid),
		.result       (prox_result),
		.low_thresh   (prox_low),
		.high_thresh  (prox_high),
		.filter_code  (prox_filter_count),
		.irq_mask     (prox_irq_mask),
		.irq_clear    (clr_prox_q),
		.irq_pending_q(prox_irq_pending)
	);

	always @(posedge clk or posedge reset) begin
		if (reset)
			irq_n <= 1'b1;
		else
			irq_n <= !(light_irq_pending || prox_irq_pending);
	end

	led_pulser #(
		.PERIOD_CYC(LED_PERIOD[7:0])
	) u_led (
		.clk        (clk),
		.reset      (reset),
		.start      (prox_accum_start),
		.pulse_total(led_pulse_total),
		.led_drive_q(led_drive_output),
		.done_q     (led_pulses_done)
	);
endmodule // sensor_irq_wait_cfg
`default_nettype wire

/* File: sensor_cfg_defs.vh */
// Register offsets, field positions, reset values and timing for the sensor interrupt/wait block
`ifndef SENSOR_CFG_DEFS_VH
`define SENSOR_CFG_DEFS_VH
`define REG_WAIT_DURATION      5'h03
`define REG_LIGHT_LOW_LO       5'h04
`define REG_LIGHT_LOW_HI       5'h05
`define REG_LIGHT_HIGH_LO      5'h06
`define REG_LIGHT_HIGH_HI      5'h07
`define REG_PROX_LOW_LO        5'h08
`define REG_PROX_LOW_HI        5'h09
`define REG_PROX_HIGH_LO       5'h0A
`define REG_PROX_HIGH_HI       5'h0B
`define REG_FILTER_COUNTS      5'h0C
`define REG_WAIT_DRIVE_OPTIONS 5'h0D
`define REG_LED_PULSE_COUNT    5'h0E
`define REG_FIRST              5'h03
`define REG_LAST               5'h0E
`define PROX_FILTER_MSB        7
`define PROX_FILTER_LSB        4
`define LIGHT_FILTER_MSB       3
`define LIGHT_FILTER_LSB       0
`define CFG_REDUCED_DRIVE_BIT  0
`define CFG_LONG_WAIT_BIT      1
`define RST_WAIT_DURATION      8'hFF
`define RST_OTHER              8'h00
`define CMD_SELECT_BIT         7
`define CMD_TYPE_REPEAT        2'h0
`define CMD_TYPE_AUTO_INC      2'h1
`define CMD_TYPE_SPECIAL       2'h3
`define SF_CLEAR_PROX          5'h05
`define SF_CLEAR_LIGHT         5'h06
`define SF_CLEAR_BOTH          5'h07
`define CLK_PERIOD_NS          100
`define WAIT_STEP_NS           2730000
`define LED_PULSE_PERIOD_NS    16000
`define LONG_WAIT_MULT         4'hC
`define WAIT_STEPS_FULL        9'h100
`endif

/* File: persist_filter.v */
// Threshold compare and consecutive out-of-range filter for one measurement channel
`timescale 1ns/1ps
`default_nettype none
module persist_filter #(
	parameter SCALED = 0
)(
	input  wire        clk,
	input  wire        reset,
	input  wire        result_valid,
	input  wire [15:0] result,
	input  wire [15:0] low_thresh,
	input  wire [15:0] high_thresh,
	input  wire [3:0]  filter_code,
	input  wire        irq_mask,
	input  wire        irq_clear,
	output reg         irq_pending_q
);
	reg  [5:0] run_q;
	wire       out_of_range;
	wire [5:0] run_next;
	wire       fire;

	// Codes above 3 on the scaled channel count in fives
	function [5:0] needed;
		input [3:0] code;
		reg   [3:0] x;
		begin
			x = code - 4'h3;
			if (SCALED != 0 && code > 4'h3)
				needed = {x, 2'b00} + {2'b00, x};
			else
				needed = {2'b00, code};
		end
	endfunction

	assign out_of_range = (result < low_thresh) || (result > high_thresh);
	assign run_next = (run_q == 6'h3F) ? run_q : run_q + 6'h01;
	assign fire = (filter_code == 4'h0) || (out_of_range && run_next >= needed(filter_code));

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			run_q         <= 6'h00;
			irq_pending_q <= 1'b0;
		end else begin
			if (result_valid)
				run_q <= out_of_range ? run_next : 6'h00;
			// Set wins over a clear in the same cycle
			if (result_valid && fire && irq_mask)
				irq_pending_q <= 1'b1;
			else if (irq_clear)
				irq_pending_q <= 1'b0;
		end
	end
endmodule // persist_filter
`default_nettype wire

/* File: led_pulser.v */
// Burst generator for the proximity LED drive pin
`timescale 1ns/1ps
`default_nettype none
module led_pulser #(
	parameter [7:0] PERIOD_CYC = 8'hA0
)(
	input  wire       clk,
	input  wire       reset,
	input  wire       start,
	input  wire [7:0] pulse_total,
	output reg        led_drive_q,
	output reg        done_q
);
	localparam [7:0] HALF = PERIOD_CYC >> 1;
	reg       active_q;
	reg [7:0] left_q;
	reg [7:0] phase_q;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			active_q    <= 1'b0;
			left_q      <= 8'h00;
			phase_q     <= 8'h00;
			led_drive_q <= 1'b0;
			done_q      <= 1'b0;
		end else begin
			done_q      <= 1'b0;
			led_drive_q <= active_q && (phase_q < HALF);
			if (!active_q) begin
				if (start) begin
					left_q  <= pulse_total;
					phase_q <= 8'h00;
					active_q <= (pulse_total != 8'h00);
					done_q  <= (pulse_total == 8'h00);
				end
			end else if (phase_q == PERIOD_CYC - 8'h01) begin
				phase_q <= 8'h00;
				left_q  <= left_q - 8'h01;
				if (left_q == 8'h01) begin
					active_q <= 1'b0;
					done_q   <= 1'b1;
				end
			end else begin
				phase_q <= phase_q + 8'h01;
			end
		end
	end
endmodule // led_pulser
`default_nettype wire

/* File: sensor_irq_wait_cfg_assertions.sv */
// Port-level checks for the sensor interrupt, wait and LED block
`timescale 1ns/1ps
`default_nettype none
module sensor_irq_wait_cfg_assertions #(
	parameter integer WAIT_STEP_CYC = 4
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic prox_irq_mask,
	input wire logic light_irq_mask,
	input wire logic wait_enable,
	input wire logic wait_start,
	input wire logic light_result_valid,
	input wire logic prox_result_valid,
	input wire logic irq_n,
	input wire logic prox_irq_pending,
	input wire logic light_irq_pending,
	input wire logic led_drive_output,
	input wire logic led_pulses_done,
	input wire logic wait_busy,
	input wire logic wait_done
);
	logic [7:0]  hi_cnt_q;
	logic [7:0]  quiet_cnt_q;
	logic [31:0] busy_cnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Quiet count saturates so an idle bus never wraps back to look busy
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hi_cnt_q    <= 8'h00;
			quiet_cnt_q <= 8'h00;
			busy_cnt_q  <= 32'h0;
		end else begin
			hi_cnt_q    <= led_drive_output ? hi_cnt_q + 8'h01 : 8'h00;
			quiet_cnt_q <= !scl_in ? 8'h00 : (quiet_cnt_q == 8'hFF ? 8'hFF : quiet_cnt_q + 8'h01);
			busy_cnt_q  <= wait_busy ? busy_cnt_q + 32'h1 : 32'h0;
		end
	end
	a_irq_follows_pend: assert property (irq_n == !($past(prox_irq_pending) || $past(light_irq_pending)))
		else $error("irq pin does not follow pending flags");
	a_prox_set_cause: assert property ($rose(prox_irq_pending) |-> $past(prox_result_valid) && $past(prox_irq_mask))
		else $error("proximity pending set without masked-in result");
	a_light_set_cause: assert property ($rose(light_irq_pending) |-> $past(light_result_valid) && $past(light_irq_mask))
		else $error("light pending set without masked-in result");
	a_pend_hold_idle: assert property ($fell(prox_irq_pending) || $fell(light_irq_pending) |-> quiet_cnt_q < 8'h10)
		else $error("pending dropped while bus idle");
	a_wait_step_mult: assert property ($fell(wait_busy) |-> busy_cnt_q >= WAIT_STEP_CYC && busy_cnt_q % WAIT_STEP_CYC == 0)
		else $error("wait length not a whole number of steps");
	a_wait_skip_off: assert property (wait_start && !wait_busy && !wait_enable |=> wait_done && !wait_busy)
		else $error("disabled wait did not finish at once");
	a_wait_runs_on: assert property (wait_start && !wait_busy && wait_enable |=> wait_busy [*2])
		else $error("enabled wait did not start");
	a_wait_done_pulse: assert property (wait_done |=> !wait_done)
		else $error("wait done longer than one cycle");
	a_led_high_len: assert property ($fell(led_drive_output) |-> hi_cnt_q == 8'h50)
		else $error("LED pulse high time wrong");
	a_led_done_quiet: assert property (led_pulses_done |-> !led_drive_output ##1 !led_pulses_done)
		else $error("burst done while LED high or too long");
endmodule // sensor_irq_wait_cfg_assertions
bind sensor_irq_wait_cfg sensor_irq_wait_cfg_assertions #(.WAIT_STEP_CYC(WAIT_STEP_CYC)) u_chk (
	.clk(clk), .reset(reset), .scl_in(scl_in), .prox_irq_mask(prox_irq_mask),
	.light_irq_mask(light_irq_mask), .wait_enable(wait_enable), .wait_start(wait_start),
	.light_result_valid(light_result_valid), .prox_result_valid(prox_result_valid),
	.irq_n(irq_n), .prox_irq_pending(prox_irq_pending), .light_irq_pending(light_irq_pending),
	.led_drive_output(led_drive_output), .led_pulses_done(led_pulses_done),
	.wait_busy(wait_busy), .wait_done(wait_done));
`default_nettype wire

/* File: i2c_host.sv */
// Two-wire bus host model driving SCL and pulling SDA low
`timescale 1ns/1ps
`default_nettype none
module i2c_host #(
	parameter logic [6:0] ADDR = 7'h2A
)(
	input  wire logic clk,
	input  wire logic sda,
	output var logic  scl,
	output var logic  pull_low
);
	int nacks;
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
		nacks = 0;
	end
	// Four clocks per half period keeps above the three-clock minimum
	task hp; repeat (4) @(negedge clk); endtask
	task bus_start; pull_low = 1'b0; hp; scl = 1'b1; hp; pull_low = 1'b1; hp; scl = 1'b0; endtask
	task bus_stop; pull_low = 1'b1; hp; scl = 1'b1; hp; pull_low = 1'b0; hp; endtask
	task clk_bit(input logic b, output logic r);
		pull_low = !b; hp; scl = 1'b1; hp; r = sda; scl = 1'b0;
	endtask
	task send(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
		clk_bit(1'b1, r);
		if (r) nacks++;
	endtask
	task wr(input logic [7:0] cmd, input int n, input logic [31:0] d);
		bus_start; send({ADDR, 1'b0}); send(cmd);
		for (int i = 0; i < n; i++) send(d[8*i+:8]);
		bus_stop;
	endtask
	task rd(input logic [4:0] a, output logic [7:0] d);
		logic r;
		bus_start; send({ADDR, 1'b0}); send({3'b100, a});
		bus_start; send({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin clk_bit(1'b1, r); d[i] = r; end
		clk_bit(1'b1, r);
		bus_stop;
	endtask
	task clr(input logic [4:0] f); wr({3'b111, f}, 0, 32'h0); endtask
endmodule // i2c_host
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the sensor wait, interrupt and LED block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, reset, scl, pull_low, sda_oe, sda_out, irq_n, prox_pend, light_pend;
	logic        prox_mask, light_mask, wait_en, wait_go, light_vld, prox_vld, accum_go;
	logic        low_drive, led, led_done, busy, done;
	logic [15:0] light_val, prox_val;
	logic [7:0]  d;
	int          error_cnt, check_count, cycles;
	wire         sda = !pull_low && (sda_oe ? sda_out : 1'b1);
	sensor_irq_wait_cfg #(.WAIT_STEP_CYC(4)) u_sensor_irq_wait_cfg (.clk(clk), .reset(reset),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .prox_irq_mask(prox_mask),
		.light_irq_mask(light_mask), .wait_enable(wait_en), .wait_start(wait_go),
		.light_channel_zero(light_val), .light_result_valid(light_vld), .prox_result(prox_val),
		.prox_result_valid(prox_vld), .prox_accum_start(accum_go), .irq_n(irq_n),
		.prox_irq_pending(prox_pend), .light_irq_pending(light_pend), .reduced_led_drive(low_drive),
		.led_drive_output(led), .led_pulses_done(led_done), .wait_busy(busy), .wait_done(done));
	i2c_host u_i2c_host (.clk(clk), .sda(sda), .scl(scl), .pull_low(pull_low));
	initial begin clk = 1'b0; forever #50 clk = ~clk; end
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin error_cnt++; report_and_stop; end
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin error_cnt++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end
	endtask
	task res(input logic lt, input logic [15:0] v);
		if (lt) begin light_val = v; light_vld = 1'b1; end else begin prox_val = v; prox_vld = 1'b1; end
		@(negedge clk); light_vld = 1'b0; prox_vld = 1'b0; repeat (2) @(negedge clk);
	endtask
	task t_regs;
		u_i2c_host.rd(5'h03, d); chk("wait reset", 16'h00FF, d);
		for (int a = 4; a <= 14; a++) begin
			u_i2c_host.rd(a[4:0], d); chk("reg reset", 16'h0000, d);
		end
		for (int a = 3; a <= 14; a++) u_i2c_host.wr({3'b100, a[4:0]}, 1, {a[3:0], ~a[3:0]});
		for (int a = 3; a <= 14; a++) begin
			u_i2c_host.rd(a[4:0], d); chk("reg rw", {8'h00, a[3:0], ~a[3:0]}, d);
		end
		u_i2c_host.wr(8'h90, 1, 32'h77); u_i2c_host.rd(5'h10, d);
		chk("unmapped", 16'h0000, d);
		u_i2c_host.wr(8'h8E, 2, 32'h0805); u_i2c_host.rd(5'h0E, d);
		chk("repeat mode", 16'h0008, d);
		u_i2c_host.wr(8'h8D, 1, 32'h01); chk("reduced drive", 16'h0001, low_drive);
		u_i2c_host.wr(8'h8D, 1, 32'h00); chk("full drive", 16'h0000, low_drive);
		$display("register test finished");
	endtask
	task t_wait;
		int n, e;
		logic [7:0] w;
		for (int i = 0; i < 4; i++) begin
			w = (i == 1) ? 8'hFE : (i == 2) ? 8'h00 : 8'hFF;
			u_i2c_host.wr(8'h83, 1, w);
			u_i2c_host.wr(8'h8D, 1, (i == 1) ? 32'h02 : 32'h00);
			e = (i == 3) ? 0 : (256 - w) * 4 * ((i == 1) ? 12 : 1);
			wait_en = (i != 3); wait_go = 1'b1; @(negedge clk); wait_go = 1'b0; n = 0;
			chk("wait busy", {15'h0000, i != 3}, {15'h0000, busy});
			while (done !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
			chk("wait cycles", e[15:0], n[15:0]);
		end
		u_i2c_host.wr(8'h8D, 1, 32'h00);
		$display("wait test finished");
	endtask
	task t_prox;
		u_i2c_host.wr(8'hA8, 4, 32'h02000100); u_i2c_host.wr(8'h8C, 1, 32'h30);
		res(0, 16'h0201); res(0, 16'h00FF); res(0, 16'h0200); res(0, 16'h0201); res(0, 16'h0201);
		chk("prox early", 16'h0000, prox_pend);
		res(0, 16'h0000); chk("prox set", 16'h0001, prox_pend); chk("irq low", 16'h0000, irq_n);
		chk("light quiet", 16'h0000, light_pend);
		u_i2c_host.clr(5'h05); chk("prox clr", 16'h0000, prox_pend); chk("irq high", 16'h0001, irq_n);
		u_i2c_host.wr(8'h8C, 1, 32'h00); res(0, 16'h0150); chk("prox every", 16'h0001, prox_pend);
		u_i2c_host.clr(5'h05); prox_mask = 1'b0; res(0, 16'h0000);
		chk("prox masked", 16'h0000, prox_pend); prox_mask = 1'b1;
		$display("proximity test finished");
	endtask
	task t_light;
		u_i2c_host.wr(8'hA4, 4, 32'h80001000); u_i2c_host.wr(8'h8C, 1, 32'h04);
		u_i2c_host.rd(5'h05, d); chk("light low hi", 16'h0010, d);
		for (int i = 0; i < 9; i++) res(1, (i == 4) ? 16'h1000 : (i % 2 ? 16'h0FFF : 16'hFFFF));
		chk("light early", 16'h0000, light_pend);
		res(1, 16'hFFFF); chk("light set", 16'h0001, light_pend);
		chk("prox apart", 16'h0000, prox_pend);
		res(0, 16'h0000); u_i2c_host.clr(5'h07);
		chk("both clr", 16'h0000, {prox_pend, light_pend});
		u_i2c_host.wr(8'h8C, 1, 32'h00); res(1, 16'h2000); u_i2c_host.clr(5'h06);
		chk("light clr", 16'h0000, light_pend);
		$display("light test finished");
	endtask
	task led_run(input logic [7:0] c);
		int n, hi, rises;
		logic prev;
		n = 0; hi = 0; rises = 0; prev = 1'b0;
		u_i2c_host.wr(8'h8E, 1, c);
		accum_go = 1'b1; @(negedge clk); accum_go = 1'b0;
		while (led_done !== 1'b1 && n < 3000) begin
			@(negedge clk); n++; hi += led; rises += (led && !prev); prev = led;
		end
		chk("pulses", {8'h00, c}, rises[15:0]);
		chk("high time", c * 16'd80, hi[15:0]);
		chk("burst len", c * 16'h00A0, n[15:0]);
	endtask
	initial begin
		reset = 1'b1; prox_mask = 1'b1; light_mask = 1'b1; wait_en = 1'b0; wait_go = 1'b0;
		light_vld = 1'b0; prox_vld = 1'b0; accum_go = 1'b0; light_val = 16'h0000;
		prox_val = 16'h0000; error_cnt = 0; check_count = 0; cycles = 0;
		repeat (20) @(negedge clk);
		reset = 1'b0; @(negedge clk);
		chk("irq idle", 16'h0001, irq_n);
		t_regs; t_wait; t_prox; t_light;
		led_run(8'h08); led_run(8'h00);
		$display("led test finished");
		chk("bus acks", 16'h0000, u_i2c_host.nacks[15:0]);
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
